// [include/pfc_balance_pkg.sv]
// Constants and carrier types for the balance configuration and debug flag bank.
// Assumes a serial bus command decoder outside hands over 16-bit command codes.
// Operation
// - Balance config bit 7 high detaches equalizer output from the pulse outputs.
// - Balance config bit 6 high keeps balancing running during fast-loop transients.
// - Bit 3 high stops balancing in low power once equalizer output hits limit.
// - Debug byte zero bits 7 and 6 show overheat warning and fault.
// - Debug byte zero bit 5 shows any temperature fault or warning.
// - Debug byte zero bit 4 shows a fault outside standard status bits 15 to 1.
// - Debug byte zero bit 3 shows any vendor-specific fault or warning.
// - Debug byte zero bit 2 shows the supply-on request inactive.
// - Debug byte zero bit 1 reads one when the output-good pin is low.
// - Debug byte zero bit 0 reads one when the input-good pin is low.
// - Debug byte one bit 7 shows nonvolatile memory unlocked.
// - Debug byte one bit 6 shows downloaded memory contents failed the check.
// - Debug byte one bit 5 shows an unreliable address-select resistor value.
// - Debug byte one bit 4 shows fast-loop compensation filter active.
// - Debug byte one bits 3 and 2 show maximum and minimum modulation reached.
// - Debug byte one bit 1 shows soft start running.
// - Debug byte one bit 0 shows lock to external synchronization.
package pfc_balance_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Command codes
  localparam logic [15:0] BALANCE_CONFIG_OFS = 16'hFE95;
  localparam logic [15:0] DEBUG_FLAGS_ZERO_OFS = 16'hFE96;
  localparam logic [15:0] DEBUG_FLAGS_ONE_OFS = 16'hFE97;

  ////////////////////////////////////////////////////////////////////////////
  // Balance configuration fields
  localparam int EQ_DETACH_BIT = 7;
  localparam int EQ_TRANSIENT_RUN_BIT = 6;
  localparam int EQ_LOWPWR_STOP_BIT = 3;
  localparam logic [7:0] BALANCE_CONFIG_WMASK = 8'hC8;
  localparam logic [7:0] BALANCE_CONFIG_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Debug byte zero fields
  localparam int DF0_OVERHEAT_WARN_BIT = 7;
  localparam int DF0_OVERHEAT_FAULT_BIT = 6;
  localparam int DF0_TEMPERATURE_BIT = 5;
  localparam int DF0_UNKNOWN_BIT = 4;
  localparam int DF0_VENDOR_FAULT_BIT = 3;
  localparam int DF0_SUPPLY_OFF_BIT = 2;
  localparam int DF0_OUTPUT_GOOD_BIT = 1;
  localparam int DF0_INPUT_GOOD_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Debug byte one fields
  localparam int DF1_NVM_UNLOCKED_BIT = 7;
  localparam int DF1_NVM_CRC_BIT = 6;
  localparam int DF1_ADDR_MARGINAL_BIT = 5;
  localparam int DF1_FAST_LOOP_BIT = 4;
  localparam int DF1_MAX_MOD_BIT = 3;
  localparam int DF1_MIN_MOD_BIT = 2;
  localparam int DF1_SOFT_START_BIT = 1;
  localparam int DF1_SYNC_LOCK_BIT = 0;
  localparam logic [7:0] DEBUG_FLAGS_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Live status conditions from the rest of the controller
  typedef struct packed {
    logic unknown_fault;
    logic supply_on_request;
    logic output_good_pin;
    logic input_good_pin;
    logic nvm_unlocked;
    logic nvm_crc_error;
    logic addr_marginal;
    logic fast_loop_active;
    logic max_modulation;
    logic min_modulation;
    logic soft_start;
    logic sync_locked;
  } status_cond_t;

  // Equalizer loop hints
  typedef struct packed {
    logic fast_loop_trigger;
    logic low_power_mode;
    logic eq_at_limit;
  } eq_cond_t;

endpackage

// [design/pfc_balance_regs.sv]
// Balance configuration register, two live debug flag bytes and equalizer gating.
// Assumes an outside command decoder gives one-cycle read and write strobes.
`timescale 1ns/1ns
module pfc_balance_regs
#(
  parameter int TEMP_W = 16,
  parameter int EQ_W = 10
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [TEMP_W-1:0] temp_measured,
  input wire logic [TEMP_W-1:0] overheat_warning_threshold,
  input wire logic [TEMP_W-1:0] overheat_fault_threshold,
  input wire logic [23:0] vendor_fault_bits,
  input wire pfc_balance_pkg::status_cond_t status_cond,
  input wire pfc_balance_pkg::eq_cond_t eq_cond,
  input wire logic [EQ_W-1:0] phase_current_equalizer_in,
  output logic [EQ_W-1:0] phase_current_equalizer_out,
  output logic phase_current_equalizer_run,
  output logic [7:0] balance_config,
  output logic [7:0] debug_flags_zero,
  output logic [7:0] debug_flags_one
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Strictly above threshold
  function automatic logic above(input logic [TEMP_W-1:0] val,
                                 input logic [TEMP_W-1:0] lim);
    above = (val > lim);
  endfunction

  logic [7:0] balance_config_r;
  logic overheat_warning_r;
  logic overheat_fault_r;
  logic temperature_any_r;
  logic unknown_fault_r;
  logic vendor_fault_r;
  logic supply_off_r;
  logic output_good_low_r;
  logic input_good_low_r;
  logic nvm_unlocked_r;
  logic nvm_crc_error_r;
  logic addr_marginal_r;
  logic fast_loop_active_r;
  logic max_modulation_r;
  logic min_modulation_r;
  logic soft_start_r;
  logic sync_locked_r;
  logic [7:0] debug_byte_zero;
  logic [7:0] debug_byte_one;
  logic [7:0] reg_rdata_r;
  logic reg_rvalid_r;
  logic [EQ_W-1:0] eq_out_r;
  logic eq_run_r;
  logic overheat_warning_flag;
  logic overheat_fault_flag;
  logic vendor_fault_flag;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register

  // Only writable bits are stored; reserved bits stay zero
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      balance_config_r <= pfc_balance_pkg::BALANCE_CONFIG_RESET;
    else if (reg_wr && reg_addr == pfc_balance_pkg::BALANCE_CONFIG_OFS)
      balance_config_r <= reg_wdata & pfc_balance_pkg::BALANCE_CONFIG_WMASK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Live debug conditions

  // Temperature and vendor comparisons
  assign overheat_warning_flag = above(temp_measured, overheat_warning_threshold);
  assign overheat_fault_flag = above(temp_measured, overheat_fault_threshold);
  assign vendor_fault_flag = |vendor_fault_bits;

  // Overheat warning, resampled every clock with no latching
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      overheat_warning_r <= 1'b0;
    else
      overheat_warning_r <= overheat_warning_flag;
  end

  // Overheat fault, resampled every clock
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      overheat_fault_r <= 1'b0;
    else
      overheat_fault_r <= overheat_fault_flag;
  end

  // Any temperature condition
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      temperature_any_r <= 1'b0;
    else
      temperature_any_r <= overheat_warning_flag | overheat_fault_flag;
  end

  // Condition outside the standard status word
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      unknown_fault_r <= 1'b0;
    else
      unknown_fault_r <= status_cond.unknown_fault;
  end

  // Any vendor fault byte bit
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      vendor_fault_r <= 1'b0;
    else
      vendor_fault_r <= vendor_fault_flag;
  end

  // Supply-on request inactive
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      supply_off_r <= 1'b0;
    else
      supply_off_r <= ~status_cond.supply_on_request;
  end

  // Output-good pin driven low
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      output_good_low_r <= 1'b0;
    else
      output_good_low_r <= ~status_cond.output_good_pin;
  end

  // Input-good pin driven low
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      input_good_low_r <= 1'b0;
    else
      input_good_low_r <= ~status_cond.input_good_pin;
  end

  // Nonvolatile memory open for writing
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      nvm_unlocked_r <= 1'b0;
    else
      nvm_unlocked_r <= status_cond.nvm_unlocked;
  end

  // Downloaded memory image failed its check
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      nvm_crc_error_r <= 1'b0;
    else
      nvm_crc_error_r <= status_cond.nvm_crc_error;
  end

  // Address-select resistor near a boundary
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      addr_marginal_r <= 1'b0;
    else
      addr_marginal_r <= status_cond.addr_marginal;
  end

  // Fast-loop filter in use
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      fast_loop_active_r <= 1'b0;
    else
      fast_loop_active_r <= status_cond.fast_loop_active;
  end

  // Maximum modulation reached
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      max_modulation_r <= 1'b0;
    else
      max_modulation_r <= status_cond.max_modulation;
  end

  // Minimum modulation reached
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      min_modulation_r <= 1'b0;
    else
      min_modulation_r <= status_cond.min_modulation;
  end

  // Soft start running
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      soft_start_r <= 1'b0;
    else
      soft_start_r <= status_cond.soft_start;
  end

  // Locked to external synchronization
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      sync_locked_r <= 1'b0;
    else
      sync_locked_r <= status_cond.sync_locked;
  end

  // Byte zero as the host reads it; gaps keep the reset value
  always_comb
  begin
    debug_byte_zero = pfc_balance_pkg::DEBUG_FLAGS_RESET;
    debug_byte_zero[pfc_balance_pkg::DF0_OVERHEAT_WARN_BIT] = overheat_warning_r;
    debug_byte_zero[pfc_balance_pkg::DF0_OVERHEAT_FAULT_BIT] = overheat_fault_r;
    debug_byte_zero[pfc_balance_pkg::DF0_TEMPERATURE_BIT] = temperature_any_r;
    debug_byte_zero[pfc_balance_pkg::DF0_UNKNOWN_BIT] = unknown_fault_r;
    debug_byte_zero[pfc_balance_pkg::DF0_VENDOR_FAULT_BIT] = vendor_fault_r;
    debug_byte_zero[pfc_balance_pkg::DF0_SUPPLY_OFF_BIT] = supply_off_r;
    debug_byte_zero[pfc_balance_pkg::DF0_OUTPUT_GOOD_BIT] = output_good_low_r;
    debug_byte_zero[pfc_balance_pkg::DF0_INPUT_GOOD_BIT] = input_good_low_r;
  end

  // Byte one as the host reads it; gaps keep the reset value
  always_comb
  begin
    debug_byte_one = pfc_balance_pkg::DEBUG_FLAGS_RESET;
    debug_byte_one[pfc_balance_pkg::DF1_NVM_UNLOCKED_BIT] = nvm_unlocked_r;
    debug_byte_one[pfc_balance_pkg::DF1_NVM_CRC_BIT] = nvm_crc_error_r;
    debug_byte_one[pfc_balance_pkg::DF1_ADDR_MARGINAL_BIT] = addr_marginal_r;
    debug_byte_one[pfc_balance_pkg::DF1_FAST_LOOP_BIT] = fast_loop_active_r;
    debug_byte_one[pfc_balance_pkg::DF1_MAX_MOD_BIT] = max_modulation_r;
    debug_byte_one[pfc_balance_pkg::DF1_MIN_MOD_BIT] = min_modulation_r;
    debug_byte_one[pfc_balance_pkg::DF1_SOFT_START_BIT] = soft_start_r;
    debug_byte_one[pfc_balance_pkg::DF1_SYNC_LOCK_BIT] = sync_locked_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Equalizer gating

  // Detach forces a zero correction onto the pulse outputs
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      eq_out_r <= '0;
    else if (balance_config_r[pfc_balance_pkg::EQ_DETACH_BIT])
      eq_out_r <= '0;
    else
      eq_out_r <= phase_current_equalizer_in;
  end

  // Suspend on transient or on limit in low power, per config bits
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      eq_run_r <= 1'b0;
    else
      eq_run_r <=
        ~(eq_cond.fast_loop_trigger &
          ~balance_config_r[pfc_balance_pkg::EQ_TRANSIENT_RUN_BIT]) &
        ~(eq_cond.low_power_mode & eq_cond.eq_at_limit &
          balance_config_r[pfc_balance_pkg::EQ_LOWPWR_STOP_BIT]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      reg_rdata_r <= pfc_balance_pkg::READ_UNMAPPED;
    else if (reg_rd)
    begin
      case (reg_addr)
        pfc_balance_pkg::BALANCE_CONFIG_OFS: reg_rdata_r <= balance_config_r;
        pfc_balance_pkg::DEBUG_FLAGS_ZERO_OFS: reg_rdata_r <= debug_byte_zero;
        pfc_balance_pkg::DEBUG_FLAGS_ONE_OFS: reg_rdata_r <= debug_byte_one;
        default: reg_rdata_r <= pfc_balance_pkg::READ_UNMAPPED;
      endcase
    end
  end

  // Read valid pulse
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      reg_rvalid_r <= 1'b0;
    else
      reg_rvalid_r <= reg_rd;
  end

  // Outputs straight from flops
  assign reg_rdata = reg_rdata_r;
  assign reg_rvalid = reg_rvalid_r;
  assign phase_current_equalizer_out = eq_out_r;
  assign phase_current_equalizer_run = eq_run_r;
  assign balance_config = balance_config_r;
  assign debug_flags_zero = debug_byte_zero;
  assign debug_flags_one = debug_byte_one;

endmodule

// [test/host_model.sv]
// Host side model: issues register accesses on the bank's port.
// Assumes one-cycle strobes and read data one cycle after the strobe edge.
`timescale 1ns/1ns
module host_model (
  input wire logic sys_clk,
  output logic [15:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  // Idle port at time zero
  initial
  begin
    {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
  end
  // One access; released address and data show the inverse of the last value, strobes drop to zero
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic v);
    @(negedge sys_clk);
    {reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, w, !w};
    @(negedge sys_clk);
    {q, v} = {reg_rdata, reg_rvalid};
    {reg_addr, reg_wdata, reg_wr, reg_rd} = {~a, ~d, 2'b00};
  endtask
  // Advised host setting: pause on transients, stop at limit
  task automatic advised(output logic [7:0] q);
    logic v;
    xfer(1'b1, pfc_balance_pkg::BALANCE_CONFIG_OFS, 8'h08, q, v);
  endtask
endmodule

// [test/pfc_balance_props.sv]
// Checker for the balance configuration and debug flag bank.
// Sees only the bank's ports; attached by the bind at the foot.
`timescale 1ns/1ns
module pfc_balance_props #(parameter int EQ_W = 10) (
  input wire logic sys_clk, rst_n, reg_wr, reg_rd, reg_rvalid,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata, reg_rdata, balance_config,
  input wire logic [7:0] debug_flags_zero, debug_flags_one,
  input wire logic [23:0] vendor_fault_bits,
  input wire pfc_balance_pkg::status_cond_t status_cond,
  input wire pfc_balance_pkg::eq_cond_t eq_cond,
  input wire logic [EQ_W-1:0] phase_current_equalizer_out,
  input wire logic phase_current_equalizer_run
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Expected read data for the address on the port
  logic [7:0] rd_mux;
  assign rd_mux = reg_addr == 16'hFE95 ? balance_config : reg_addr == 16'hFE96 ?
    debug_flags_zero : reg_addr == 16'hFE97 ? debug_flags_one : 8'h00;
  sequence cfg_write;
    reg_wr && reg_addr == pfc_balance_pkg::BALANCE_CONFIG_OFS;
  endsequence
  sequence read_req;
    reg_rd;
  endsequence
  a_byte_one_live: assert property ($past(rst_n) |-> debug_flags_one == $past(status_cond[7:0]))
    else $error("byte one flags wrong");
  a_byte_zero_low: assert property ($past(rst_n) |-> debug_flags_zero[4:0] ==
    $past({status_cond[11], |vendor_fault_bits, ~status_cond[10:8]})) else $error("byte zero low");
  a_temp_any: assert property (debug_flags_zero[5] == |debug_flags_zero[7:6])
    else $error("temperature summary wrong");
  a_eq_detach: assert property ($past(rst_n) && $past(balance_config[7]) |->
    phase_current_equalizer_out == '0) else $error("detached output not zero");
  a_run_gate: assert property ($past(rst_n) |-> phase_current_equalizer_run ==
    $past(!(eq_cond[2] && !balance_config[6]) && !(eq_cond[1] && eq_cond[0] && balance_config[3])))
    else $error("run gating wrong");
  a_read_data: assert property (read_req |=> reg_rvalid && reg_rdata == $past(rd_mux))
    else $error("read answer wrong");
  a_cfg_write: assert property (cfg_write |=> balance_config == ($past(reg_wdata) & 8'hC8))
    else $error("config write wrong");
  a_cfg_hold: assert property (!(reg_wr && reg_addr == 16'hFE95) |=> $stable(balance_config))
    else $error("config changed");
endmodule
bind pfc_balance_regs pfc_balance_props #(.EQ_W(EQ_W)) pfc_balance_props_inst (.sys_clk, .rst_n,
  .reg_wr, .reg_rd, .reg_rvalid, .reg_addr, .reg_wdata, .reg_rdata, .balance_config,
  .debug_flags_zero, .debug_flags_one, .vendor_fault_bits, .status_cond, .eq_cond,
  .phase_current_equalizer_out, .phase_current_equalizer_run);

// [test/test_pfc_balance_cfg_and_debug_flags.sv]
// Self-checking bench for the balance configuration and debug flag bank.
// Assumes host_model drives the register port; inputs change at falling edges.
`timescale 1ns/1ns
module test_pfc_balance_cfg_and_debug_flags;
  logic sys_clk = 0;
  logic rst_n = 0;
  logic [15:0] reg_addr, temp, warn_lim, fault_lim;
  logic reg_wr, reg_rd, reg_rvalid, eq_run, v;
  logic [7:0] reg_wdata, reg_rdata, cfg, df0, df1, q;
  logic [23:0] vend;
  pfc_balance_pkg::status_cond_t sc;
  pfc_balance_pkg::eq_cond_t ec;
  logic [9:0] eq_in, eq_out;
  int num_errors = 0;
  int check_count = 0;
  initial forever #20 sys_clk = ~sys_clk;
  pfc_balance_regs pfc_balance_regs_inst (.sys_clk, .rst_n, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .reg_rvalid, .temp_measured(temp), .overheat_warning_threshold(warn_lim),
    .overheat_fault_threshold(fault_lim), .vendor_fault_bits(vend), .status_cond(sc), .eq_cond(ec),
    .phase_current_equalizer_in(eq_in), .phase_current_equalizer_out(eq_out),
    .phase_current_equalizer_run(eq_run), .balance_config(cfg), .debug_flags_zero(df0),
    .debug_flags_one(df1));
  host_model host_model_inst (.sys_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .reg_rvalid);
  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // Read one register and check the valid pulse
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    host_model_inst.xfer(1'b0, a, 8'h00, d, v);
    chk("rvalid", v, 16'h0001);
  endtask
  // Reserved bits, read-only bytes, unmapped code
  task automatic t_config();
    rd(16'hFE95, q);
    chk("cfg_reset", q, 8'h00);
    host_model_inst.xfer(1'b1, 16'hFE95, 8'hFF, q, v);
    host_model_inst.xfer(1'b1, 16'hFE96, 8'hFF, q, v);
    host_model_inst.xfer(1'b1, 16'hFE97, 8'hFF, q, v);
    rd(16'hFE95, q);
    chk("cfg_wr", q, 8'hC8);
    chk("cfg_port", cfg, 8'hC8);
    rd(16'hFE96, q);
    chk("df0_ro", q, 8'h07);
    rd(16'hFE97, q);
    chk("df1_ro", q, 8'h00);
    rd(16'hFE98, q);
    chk("unmapped", q, 8'h00);
    host_model_inst.advised(q);
    rd(16'hFE95, q);
    chk("cfg_adv", q, 8'h08);
    $display("test config done");
  endtask
  // Walking one over every condition, then temperature and vendor cases
  task automatic t_flags();
    for (int i = 0; i < 14; i++)
    begin
      sc = pfc_balance_pkg::status_cond_t'(12'h001 << i);
      temp = i == 12 ? 16'h0065 : i == 13 ? 16'h00C9 : 16'h0064;
      vend = i == 13 ? 24'h800000 : 24'h000000;
      rd(16'hFE96, q);
      chk("flags0", q, {temp > 16'h0064, temp > 16'h00C8, temp > 16'h0064, sc[11], |vend,
        ~sc[10:8]});
      rd(16'hFE97, q);
      chk("flags1", q, sc[7:0]);
      chk("df1_port", df1, sc[7:0]);
    end
    $display("test flags done");
  endtask
  // Detach and run gating over all setting combinations
  task automatic t_eq();
    for (int j = 0; j < 32; j++)
    begin
      ec = {j[2], j[3], j[3]};
      eq_in = 10'h155 ^ 10'(j);
      host_model_inst.xfer(1'b1, 16'hFE95, {j[4], j[0], 2'b00, j[1], 3'b000}, q, v);
      @(negedge sys_clk);
      chk("eq_out", eq_out, j[4] ? 10'h000 : eq_in);
      chk("eq_run", eq_run, !(j[2] && !j[0]) && !(j[3] && j[1]));
    end
    $display("test equalizer done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    final_report();
  end
  // Main sequence
  initial
  begin
    {temp, vend, sc, ec, eq_in} = '0;
    warn_lim = 16'h0064;
    fault_lim = 16'h00C8;
    repeat (3) @(negedge sys_clk);
    rst_n = 1;
    t_config();
    t_flags();
    t_eq();
    final_report();
  end
endmodule
